// file: pkg/osc_defines.svh
// Register indices, field positions, reset values and timing counts of the config block
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// Register indices; byte address is four times the index
`define OSC_IDX_SLOT_ONE 6'h09
`define OSC_IDX_SLOT_TWO 6'h0A
`define OSC_IDX_SYS_CTRL 6'h0D
`define OSC_IDX_ACQ_ONE 6'h0E
`define OSC_IDX_IRQ_STATUS 6'h20
`define OSC_IDX_IRQ_MASK 6'h21
`define OSC_IDX_QUEUE_STATUS 6'h22
`define OSC_IDX_QUEUE_DATA 6'h23

// Reset values
`define OSC_SLOT_RESET 8'h00
`define OSC_SYS_RESET 8'h00
`define OSC_ACQ_RESET 8'h00
`define OSC_MASK_RESET 4'h0

// System control bit positions
`define OSC_SYS_RESET_BIT 0
`define OSC_SYS_SAVE_BIT 1
`define OSC_SYS_QEN_BIT 2

// Interrupt status bit positions
`define OSC_IRQ_READY 0
`define OSC_IRQ_FULL 1
`define OSC_IRQ_LOST 2
`define OSC_IRQ_CLAMP 3
`define OSC_IRQ_BITS 4

// Queue geometry
`define OSC_QUEUE_DEPTH 32
`define OSC_QUEUE_AW 5
`define OSC_ELEM_BITS 24
`define OSC_ELEMS 4

// Slot data-type codes
`define OSC_SLOT_E1_OPT 4'h1
`define OSC_SLOT_E3_OPT 4'h3
`define OSC_SLOT_E1_PILOT 4'h5
`define OSC_SLOT_E3_PILOT 4'h7

// Sample rate codes; all but OSC_SR_84_N1 used as limits
`define OSC_SR_84_N1 4'h3
`define OSC_SR_400 4'h6
`define OSC_SR_800 4'h7
`define OSC_SR_1000 4'h8
`define OSC_SR_1600 4'h9
`define OSC_SR_3200 4'hA
`define OSC_SR_84_N2 4'hE
`define OSC_SR_100_N2 4'hF

// Forced reset sequence length
`define OSC_CLK_MHZ 100
`define OSC_SRST_NS 160
`define OSC_SRST_CYCLES ((`OSC_SRST_NS * `OSC_CLK_MHZ) / 1000)

`endif

// file: pkg/osc_pkg.sv
// Types shared by the optical sensor config block
package osc_pkg;

    // System sequencing state, Gray coded along run, drain, sleep
    typedef enum logic [1:0] {
        OSC_RUN = 2'b00,
        OSC_DRAIN = 2'b01,
        OSC_SLEEP = 2'b11,
        OSC_SRST = 2'b10
    } osc_state_t;

    // One sample from the front end: four 24-bit elements
    typedef struct packed {
        logic [3:0][23:0] elem;
    } osc_sample_t;

    // Applied acquisition settings driven to the front end
    typedef struct packed {
        logic [1:0] optical_adc_range;
        logic [3:0] optical_sample_rate;
        logic [1:0] emitter_pulse_width;
        logic [3:0] slot3_data_type;
    } osc_acq_cfg_t;

endpackage

// file: design/osc_config.sv
// Optical sensor system control, acquisition config and sample queue behind APB
//
// What this block does
// - Queue holds 32 samples of four 24-bit elements
// - Slot-3 codes 1,3,5,7 valid; others reserved
// - Queue disabled: no push, data frozen; host reads still advance pointers
// - Queue enable written while off flushes and restarts at zero
// - Power-save keeps registers and bus access working
// - Power-save clears interrupt flags and holds them
// - Power-save stops oscillator; results stay frozen
// - Running conversion finishes before entering power-save
// - Reset bit forces full power-on register reset
// - Reset bit clears itself after the sequence
// - Two-bit ADC range field selects LSB/full scale
// - Four-bit sample rate code, N=1 or N=2
// - Unsupported rate clamps to highest; reads show applied
// - Acquisition register: range 7:6, rate 5:2, width 1:0
// - Pulse width field sets pulse and integration time
`include "osc_defines.svh"

module osc_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire osc_pkg::osc_sample_t sample_in,
    input wire logic conv_busy,
    output osc_pkg::osc_acq_cfg_t acq_cfg,
    output logic osc_run,
    output logic soft_reset_active,
    output logic irq
);
    import osc_pkg::*;

    // Slot code decode, shared by all four slots
    function automatic logic osc_slot_valid(input logic [3:0] code);
        return (code == `OSC_SLOT_E1_OPT) || (code == `OSC_SLOT_E3_OPT) ||
               (code == `OSC_SLOT_E1_PILOT) || (code == `OSC_SLOT_E3_PILOT);
    endfunction

    function automatic logic osc_is_e1(input logic [3:0] code);
        return (code == `OSC_SLOT_E1_OPT) || (code == `OSC_SLOT_E1_PILOT);
    endfunction

    function automatic logic osc_is_e3(input logic [3:0] code);
        return (code == `OSC_SLOT_E3_OPT) || (code == `OSC_SLOT_E3_PILOT);
    endfunction

    // Highest supported rate for pulse width and emitter count
    function automatic logic [3:0] osc_clamp_rate(input logic [3:0] sr, input logic [1:0] pw,
                                                  input logic two);
        logic [3:0] lim;
        lim = `OSC_SR_100_N2;
        if (sr <= `OSC_SR_3200) begin
            case (pw)
                2'h0: lim = two ? `OSC_SR_1600 : `OSC_SR_3200;
                2'h1: lim = two ? `OSC_SR_800 : `OSC_SR_1600;
                2'h2: lim = two ? `OSC_SR_800 : `OSC_SR_1000;
                default: lim = two ? `OSC_SR_400 : `OSC_SR_1000;
            endcase
        end else begin
            lim = (two && (pw == 2'h3)) ? `OSC_SR_84_N2 : `OSC_SR_100_N2;
        end
        return (sr > lim) ? lim : sr;
    endfunction

    // Registers
    osc_state_t state;
    logic [7:0] slot_control_one;
    logic [7:0] slot_control_two;
    logic queue_enable;
    logic power_save;
    logic [1:0] optical_adc_range;
    logic [3:0] rate_stored;
    logic [1:0] emitter_pulse_width;
    logic [`OSC_IRQ_BITS-1:0] irq_status;
    logic [`OSC_IRQ_BITS-1:0] irq_mask;
    logic [7:0] srst_count;

    // Queue storage
    osc_sample_t queue_mem [`OSC_QUEUE_DEPTH];
    logic [3:0] queue_present [`OSC_QUEUE_DEPTH];
    logic [`OSC_QUEUE_AW-1:0] wr_ptr;
    logic [`OSC_QUEUE_AW-1:0] rd_ptr;
    logic [`OSC_QUEUE_AW:0] count;
    logic [1:0] elem_idx;

    // Bus decode
    logic [5:0] index;
    logic setup;
    logic access_wr;
    logic access_rd;
    logic mapped;
    logic lane0;
    logic next_err;

    // Derived
    logic [3:0] slot_codes [`OSC_ELEMS];
    logic [3:0] present_mask;
    logic two_emitters;
    logic [3:0] rate_applied;
    logic [3:0] rate_written;
    logic full;
    logic push;
    logic pop;
    logic flush;
    logic sys_write;
    logic acq_write;
    logic [`OSC_IRQ_BITS-1:0] irq_set;
    logic srst_start;
    logic srst_done;
    logic [31:0] next_prdata;

    assign index = paddr[7:2];
    assign setup = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign access_rd = psel && penable && !pwrite;
    assign lane0 = pstrb[0];

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;

    always_comb begin
        case (index)
            `OSC_IDX_SLOT_ONE, `OSC_IDX_SLOT_TWO, `OSC_IDX_SYS_CTRL, `OSC_IDX_ACQ_ONE,
            `OSC_IDX_IRQ_STATUS, `OSC_IDX_IRQ_MASK, `OSC_IDX_QUEUE_STATUS,
            `OSC_IDX_QUEUE_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign next_err = !mapped || (paddr[1:0] != 2'h0);

    // Slot codes, low nibble is the lower slot
    assign slot_codes[0] = slot_control_one[3:0];
    assign slot_codes[1] = slot_control_one[7:4];
    assign slot_codes[2] = slot_control_two[3:0];
    assign slot_codes[3] = slot_control_two[7:4];

    always_comb begin
        present_mask = 4'h0;
        two_emitters = 1'b0;
        for (int i = 0; i < `OSC_ELEMS; i++) begin
            present_mask[i] = osc_slot_valid(slot_codes[i]);
        end
        two_emitters = (osc_is_e1(slot_codes[0]) || osc_is_e1(slot_codes[1]) ||
                        osc_is_e1(slot_codes[2]) || osc_is_e1(slot_codes[3])) &&
                       (osc_is_e3(slot_codes[0]) || osc_is_e3(slot_codes[1]) ||
                        osc_is_e3(slot_codes[2]) || osc_is_e3(slot_codes[3]));
    end

    // applied rate follows mode changes too
    assign rate_applied = osc_clamp_rate(rate_stored, emitter_pulse_width, two_emitters);
    assign rate_written = osc_clamp_rate(pwdata[5:2], pwdata[1:0], two_emitters);

    assign sys_write = access_wr && lane0 && !pslverr && (index == `OSC_IDX_SYS_CTRL) &&
                       (state != OSC_SRST);
    assign acq_write = access_wr && lane0 && !pslverr && (index == `OSC_IDX_ACQ_ONE) &&
                       (state != OSC_SRST);
    // writing one to the reset bit starts the sequence
    assign srst_start = sys_write && pwdata[`OSC_SYS_RESET_BIT];
    assign srst_done = (state == OSC_SRST) && (srst_count == 8'(`OSC_SRST_CYCLES - 1));
    // enable written while off flushes the queue
    assign flush = sys_write && pwdata[`OSC_SYS_QEN_BIT] && !queue_enable;

    assign full = (count == (`OSC_QUEUE_AW + 1)'(`OSC_QUEUE_DEPTH));
    // no push while disabled; none once asleep
    assign push = sample_valid && queue_enable && !full && !flush &&
                  ((state == OSC_RUN) || (state == OSC_DRAIN));
    assign pop = access_rd && !pslverr && (index == `OSC_IDX_QUEUE_DATA) &&
                 (count != '0) && (elem_idx == 2'h3) && !flush;

    // Interrupt events
    always_comb begin
        irq_set = '0;
        irq_set[`OSC_IRQ_READY] = push;
        irq_set[`OSC_IRQ_FULL] = push && (count == (`OSC_QUEUE_AW + 1)'(`OSC_QUEUE_DEPTH - 1));
        irq_set[`OSC_IRQ_LOST] = sample_valid && queue_enable && full && (state != OSC_SLEEP)
                                 && (state != OSC_SRST);
        irq_set[`OSC_IRQ_CLAMP] = acq_write && (rate_written != pwdata[5:2]);
    end

    // Sequencing of power-save and forced reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= OSC_RUN;
        end else begin
            case (state)
                OSC_RUN: begin
                    if (srst_start) begin
                        state <= OSC_SRST;
                    end else if (power_save) begin
                        // let a running conversion finish first
                        state <= conv_busy ? OSC_DRAIN : OSC_SLEEP;
                    end
                end
                OSC_DRAIN: begin
                    if (srst_start) begin
                        state <= OSC_SRST;
                    end else if (!power_save) begin
                        state <= OSC_RUN;
                    end else if (!conv_busy) begin
                        state <= OSC_SLEEP;
                    end
                end
                OSC_SLEEP: begin
                    if (srst_start) begin
                        state <= OSC_SRST;
                    end else if (!power_save) begin
                        state <= OSC_RUN;
                    end
                end
                OSC_SRST: begin
                    // reset bit drops when the sequence ends
                    if (srst_done) begin
                        state <= OSC_RUN;
                    end
                end
                default: state <= OSC_RUN;
            endcase
        end
    end

    // Forced reset length counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srst_count <= 8'h00;
        end else if (state == OSC_SRST) begin
            srst_count <= srst_count + 8'h01;
        end else begin
            srst_count <= 8'h00;
        end
    end

    // Configuration registers; the forced reset returns them to power-on values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_control_one <= `OSC_SLOT_RESET;
            slot_control_two <= `OSC_SLOT_RESET;
            queue_enable <= 1'(`OSC_SYS_RESET >> `OSC_SYS_QEN_BIT);
            power_save <= 1'b0;
            optical_adc_range <= 2'h0;
            rate_stored <= 4'h0;
            emitter_pulse_width <= 2'h0;
            irq_mask <= `OSC_MASK_RESET;
        end else if (state == OSC_SRST) begin
            // every register back to power-on state
            slot_control_one <= `OSC_SLOT_RESET;
            slot_control_two <= `OSC_SLOT_RESET;
            queue_enable <= 1'b0;
            power_save <= 1'b0;
            optical_adc_range <= 2'h0;
            rate_stored <= 4'h0;
            emitter_pulse_width <= 2'h0;
            irq_mask <= `OSC_MASK_RESET;
        end else if (access_wr && lane0 && !pslverr) begin
            // writes work in every mode but reset
            case (index)
                `OSC_IDX_SLOT_ONE: slot_control_one <= pwdata[7:0];
                `OSC_IDX_SLOT_TWO: slot_control_two <= pwdata[7:0];
                `OSC_IDX_SYS_CTRL: begin
                    if (!pwdata[`OSC_SYS_RESET_BIT]) begin
                        queue_enable <= pwdata[`OSC_SYS_QEN_BIT];
                        power_save <= pwdata[`OSC_SYS_SAVE_BIT];
                    end
                end
                `OSC_IDX_ACQ_ONE: begin
                    // range 7:6, rate 5:2, width 1:0
                    optical_adc_range <= pwdata[7:6];
                    rate_stored <= rate_written;
                    emitter_pulse_width <= pwdata[1:0];
                end
                `OSC_IDX_IRQ_MASK: irq_mask <= pwdata[`OSC_IRQ_BITS-1:0];
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    // Sticky status; a new event beats a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (power_save || (state == OSC_SRST)) begin
            // flags cleared and held in power-save
            irq_status <= '0;
        end else if (access_wr && lane0 && !pslverr && (index == `OSC_IDX_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~pwdata[`OSC_IRQ_BITS-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    // Queue pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            elem_idx <= 2'h0;
        end else if (flush || (state == OSC_SRST)) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            elem_idx <= 2'h0;
        end else begin
            // pointers only move on push or host read
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (access_rd && !pslverr && (index == `OSC_IDX_QUEUE_DATA) && (count != '0)) begin
                elem_idx <= elem_idx + 2'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    // Queue storage; no reset so it maps to memory
    always_ff @(posedge pclk) begin
        if (push) begin
            // one sample of four elements per slot
            queue_mem[wr_ptr] <= sample_in;
            queue_present[wr_ptr] <= present_mask;
        end
    end

    // Read mux
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (index)
            `OSC_IDX_SLOT_ONE: next_prdata[7:0] = slot_control_one;
            `OSC_IDX_SLOT_TWO: next_prdata[7:0] = slot_control_two;
            `OSC_IDX_SYS_CTRL: begin
                next_prdata[`OSC_SYS_QEN_BIT] = queue_enable;
                next_prdata[`OSC_SYS_SAVE_BIT] = power_save;
                next_prdata[`OSC_SYS_RESET_BIT] = (state == OSC_SRST);
            end
            `OSC_IDX_ACQ_ONE: next_prdata[7:0] = {optical_adc_range, rate_applied,
                                                  emitter_pulse_width};
            `OSC_IDX_IRQ_STATUS: next_prdata[`OSC_IRQ_BITS-1:0] = irq_status;
            `OSC_IDX_IRQ_MASK: next_prdata[`OSC_IRQ_BITS-1:0] = irq_mask;
            `OSC_IDX_QUEUE_STATUS: begin
                next_prdata[5:0] = count;
                next_prdata[12:8] = rd_ptr;
                next_prdata[20:16] = wr_ptr;
                next_prdata[25:24] = elem_idx;
                next_prdata[29:28] = state;
            end
            `OSC_IDX_QUEUE_DATA: begin
                // empty slot reads zero with present clear
                if ((count != '0) && queue_present[rd_ptr][elem_idx]) begin
                    next_prdata[23:0] = queue_mem[rd_ptr].elem[elem_idx];
                    next_prdata[24] = 1'b1;
                end
            end
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_err;
        end
    end

    // Outputs to the front end, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_cfg <= '0;
            osc_run <= 1'b1;
            soft_reset_active <= 1'b0;
            irq <= 1'b0;
        end else begin
            acq_cfg <= '{optical_adc_range: optical_adc_range,
                         optical_sample_rate: rate_applied,
                         emitter_pulse_width: emitter_pulse_width,
                         slot3_data_type: slot_control_two[3:0]};
            osc_run <= (state != OSC_SLEEP);
            // distributed registers reset by this strobe
            soft_reset_active <= (state == OSC_SRST) && !srst_done;
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// file: tb/osc_config_sva.sv
// Port-level assertion checker for the optical sensor config block
`include "osc_defines.svh"
module osc_config_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic conv_busy,
    input wire osc_pkg::osc_acq_cfg_t acq_cfg,
    input wire logic osc_run,
    input wire logic soft_reset_active,
    input wire logic irq
);
    import osc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bus_wr;
    // Any completed write; a reset-bit write during the sequence is ignored
    assign bus_wr = psel && penable && pwrite;
    sequence srst_req;
        bus_wr && pstrb[0] && pwdata[0] && !soft_reset_active
            && paddr == {`OSC_IDX_SYS_CTRL, 2'b00};
    endsequence
    sequence srst_done;
        !soft_reset_active ##1 acq_cfg == '0;
    endsequence
    pready_high_a: assert property (pready)
        else $error("pready low");
    srst_start_a: assert property (srst_req |-> ##[1:2] soft_reset_active)
        else $error("forced reset not started");
    srst_len_a: assert property ($rose(soft_reset_active) |-> soft_reset_active[*8])
        else $error("forced reset too short");
    srst_bound_a: assert property (soft_reset_active |-> ##[1:40] !soft_reset_active)
        else $error("forced reset never ends");
    srst_cfg_a: assert property ($fell(soft_reset_active) |-> srst_done)
        else $error("config not reset");
    srst_irq_a: assert property (soft_reset_active && $past(soft_reset_active, 2) |-> !irq)
        else $error("irq during forced reset");
    save_irq_a: assert property (!osc_run |-> !irq)
        else $error("irq while asleep");
    drain_hold_a: assert property (conv_busy && osc_run |=> osc_run)
        else $error("slept during conversion");
    // config changes only on cause
    // Register moves at the access edge, acq_cfg one edge later, so the write is two back
    cfg_cause_a: assert property ($changed(acq_cfg) |->
        $past(bus_wr, 2) || $past(soft_reset_active) || $past(soft_reset_active, 2))
        else $error("config changed without write");
    clamp_pw_a: assert property (acq_cfg.emitter_pulse_width != 2'h0 |->
        acq_cfg.optical_sample_rate != `OSC_SR_3200)
        else $error("rate not clamped");
    clamp_wide_a: assert property (acq_cfg.emitter_pulse_width[1] |->
        !(acq_cfg.optical_sample_rate inside {`OSC_SR_1600, `OSC_SR_3200}))
        else $error("rate not clamped wide");
endmodule

// file: tb/osc_front_end.sv
// Behavioural front end that hands samples and conversion status to the block
module osc_front_end (
    input wire logic pclk,
    output logic sample_valid,
    output osc_pkg::osc_sample_t sample_in,
    output logic conv_busy
);
    import osc_pkg::*;
    // Quiet at time zero
    initial begin
        sample_valid = 1'b0;
        sample_in = '0;
        conv_busy = 1'b0;
    end
    // One-cycle pulse; data inverted afterwards so a late capture shows up
    task push(input logic [23:0] base);
        @(posedge pclk);
        sample_valid <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            sample_in.elem[i] <= base + 24'(i);
        end
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_in <= ~sample_in;
    endtask
    task set_busy(input logic b);
        @(posedge pclk);
        conv_busy <= b;
    endtask
endmodule

// file: tb/osc_config_tb_top.sv
// Self-checking bench for the optical sensor config block
`include "osc_defines.svh"
module osc_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import osc_pkg::*;
    localparam logic [7:0] a_sys = {`OSC_IDX_SYS_CTRL, 2'b00};
    localparam logic [7:0] a_acq = {`OSC_IDX_ACQ_ONE, 2'b00};
    localparam logic [7:0] a_sl2 = {`OSC_IDX_SLOT_TWO, 2'b00};
    localparam logic [7:0] a_st = {`OSC_IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] a_msk = {`OSC_IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] a_qs = {`OSC_IDX_QUEUE_STATUS, 2'b00};
    localparam logic [7:0] a_qd = {`OSC_IDX_QUEUE_DATA, 2'b00};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, sample_valid, conv_busy, osc_run, soft_reset_active, irq;
    osc_sample_t sample_in;
    osc_acq_cfg_t acq_cfg;
    int num_errors = 0, tests_run = 0;
    always #5 pclk = ~pclk;
    osc_config u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_in(sample_in), .conv_busy(conv_busy), .acq_cfg(acq_cfg),
        .osc_run(osc_run), .soft_reset_active(soft_reset_active), .irq(irq));
    osc_front_end u_fe (.pclk(pclk), .sample_valid(sample_valid), .sample_in(sample_in),
        .conv_busy(conv_busy));
    task print_verdict;
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task t_regs;
        rchk(a_sys, 32'hFF, 32'h0);
        rchk(a_acq, 32'hFF, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, a_acq, 32'hC9);
        rchk(a_acq, 32'hFF, 32'hC9);
        repeat (2) @(posedge pclk);
        chk({24'h0, acq_cfg[11:4]}, 32'hC9);
        // Byte lane 0 off: the write must leave the register alone
        pstrb <= 4'hE;
        apb(1'b1, a_acq, 32'h04);
        pstrb <= 4'hF;
        rchk(a_acq, 32'hFF, 32'hC9);
        for (int r = 0; r < 16; r++) begin
            apb(1'b1, a_acq, 32'(r << 2));
            rchk(a_acq, 32'hFF, 32'(r << 2));
        end
        apb(1'b1, a_st, 32'hF);
        apb(1'b1, a_acq, 32'h29);
        rchk(a_acq, 32'hFF, 32'h25);
        rchk(a_st, 32'h8, 32'h8);
        apb(1'b1, a_msk, 32'h8);
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, irq}, 32'h1);
        apb(1'b1, a_st, 32'h8);
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, irq}, 32'h0);
    endtask
    task t_queue;
        apb(1'b1, a_sl2, 32'h1);
        repeat (2) @(posedge pclk);
        chk({28'h0, acq_cfg[3:0]}, 32'h1);
        apb(1'b1, a_sys, 32'h4);
        u_fe.push(24'h100);
        u_fe.push(24'h200);
        rchk(a_qs, 32'h3F, 32'h2);
        rchk(a_qd, 32'hFFFFFFFF, 32'h0);
        rchk(a_qd, 32'hFFFFFFFF, 32'h0);
        rchk(a_qd, 32'hFFFFFFFF, 32'h01000102);
        rchk(a_qd, 32'hFFFFFFFF, 32'h0);
        apb(1'b1, a_sys, 32'h0);
        u_fe.push(24'h300);
        rchk(a_qs, 32'h3F, 32'h1);
        apb(1'b1, a_sys, 32'h4);
        rchk(a_qs, 32'h3F, 32'h0);
        apb(1'b1, a_st, 32'hF);
        for (int k = 0; k < 33; k++) u_fe.push(24'(k));
        rchk(a_qs, 32'h3F, 32'h20);
        rchk(a_st, 32'h6, 32'h6);
    endtask
    task t_save;
        apb(1'b1, a_msk, 32'hF);
        u_fe.set_busy(1'b1);
        apb(1'b1, a_sys, 32'h6);
        repeat (4) @(posedge pclk);
        #1 chk({31'h0, osc_run}, 32'h1);
        u_fe.set_busy(1'b0);
        repeat (5) @(posedge pclk);
        #1 chk({31'h0, osc_run}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rchk(a_st, 32'hF, 32'h0);
        rchk(a_acq, 32'hFF, 32'h25);
        apb(1'b1, a_acq, 32'h80);
        rchk(a_acq, 32'hFF, 32'h80);
        apb(1'b1, a_sys, 32'h4);
        repeat (3) @(posedge pclk);
        #1 chk({31'h0, osc_run}, 32'h1);
    endtask
    task t_srst;
        apb(1'b1, a_sys, 32'h1);
        rchk(a_sys, 32'h1, 32'h1);
        for (int k = 0; k < 40 && soft_reset_active; k++) @(posedge pclk);
        rchk(a_sys, 32'hFF, 32'h0);
        rchk(a_acq, 32'hFF, 32'h0);
        rchk(a_sl2, 32'hFF, 32'h0);
        rchk(a_msk, 32'hF, 32'h0);
        rchk(a_qs, 32'h3F, 32'h0);
    endtask
    // Reset, then scenarios in order
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_queue();
        t_save();
        t_srst();
        print_verdict();
    end
    // Cut a hang well past the expected run of a few hundred cycles
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
endmodule
bind osc_config osc_config_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .conv_busy(conv_busy), .acq_cfg(acq_cfg), .osc_run(osc_run),
    .soft_reset_active(soft_reset_active), .irq(irq));
